// ### design/aip_defines.svh
`ifndef AIP_DEFINES_SVH
`define AIP_DEFINES_SVH

// register byte offsets
`define AIP_OFS_CTRL        8'h00
`define AIP_OFS_WATCH       8'h04
`define AIP_OFS_STATUS      8'h08
`define AIP_OFS_MASK        8'h0c
`define AIP_OFS_LIVE        8'h10
`define AIP_OFS_RATE        8'h14

// control register fields
`define AIP_CTRL_IRQ_SEL    0
`define AIP_CTRL_REF1_SEL   1
`define AIP_CTRL_REF2_SEL   2
`define AIP_CTRL_IRQ_SENSE  3
`define AIP_CTRL_ALM_SENSE  4
`define AIP_CTRL_DEV_A      5
`define AIP_CTRL_DEV_B      6

// watch register: two bits per input, input a low
`define AIP_WATCH_A_LSB     0
`define AIP_WATCH_B_LSB     2

// absence watch codes
`define AIP_WATCH_OFF       2'h0
`define AIP_WATCH_RSVD      2'h1
`define AIP_WATCH_SLOW      2'h2
`define AIP_WATCH_NORMAL    2'h3

// status, mask and live layout
`define AIP_ST_ABSENT_A     0
`define AIP_ST_ABSENT_B     1
`define AIP_ST_DEV_A        2
`define AIP_ST_DEV_B        3

// reset values
`define AIP_CTRL_RST        8'h00
`define AIP_WATCH_RST       8'h00
`define AIP_MASK_RST        4'h0
`define AIP_STATUS_RST      4'h0

`endif

// ### design/aip_pkg.sv
package aip_pkg;

  // three-level pin reading, one-hot
  typedef enum logic [2:0] {
    AIP_LVL_LOW  = 3'b001,
    AIP_LVL_MID  = 3'b010,
    AIP_LVL_HIGH = 3'b100
  } aip_level_t;

  // function of the combined pin, one-hot
  typedef enum logic [2:0] {
    AIP_PIN_OFF   = 3'b001,
    AIP_PIN_IRQ   = 3'b010,
    AIP_PIN_ALARM = 3'b100
  } aip_pin_mode_t;

endpackage : aip_pkg

// ### design/aip_sync.sv
`timescale 1ns/1ps
`default_nettype none

module aip_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // two stages; the first is read by the second only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : aip_sync

`default_nettype wire

// ### design/aip_top.sv
// What this block does
// - interrupt mode: maskable, polarity from irq sense
// - ref1 select without irq select: alarm a
// - alarm a reads 0 present, 1 bad
// - alarm sense sets alarm a active level
// - nothing selected: combined pin floats
// - ref2 select: second pin shows alarm b
// - alarm sense inverts; unselected pin floats
// - three-level rate pins, undriven means mid
// - per-input deviation watch enable bit
// - absence watch: off, reserved, slow, normal
`timescale 1ns/1ps
`default_nettype none
`include "aip_defines.svh"

module aip_top (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // detector indications, per input (index 0 = a, 1 = b)
  input  wire logic [1:0] signal_absent_normal,
  input  wire logic [1:0] signal_absent_slow,
  input  wire logic [1:0] freq_deviation,
  // three-level rate pins as comparator pairs {above 3/4, above 1/4}
  input  wire logic [1:0] refrate_sel_low_cmp,
  input  wire logic [1:0] refrate_sel_high_cmp,
  // status pins
  output logic            irq_or_ref1_alarm_pin_o,
  output logic            irq_or_ref1_alarm_pin_oe,
  output logic            ref2_alarm_pin_o,
  output logic            ref2_alarm_pin_oe,
  output logic            irq_o,
  output logic      [5:0] refrate_code
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // comparator pair to three-level reading; a floating pin sits at mid
  function automatic aip_pkg::aip_level_t aip_decode_level(input logic [1:0] cmp);
    aip_pkg::aip_level_t lvl;
    lvl = aip_pkg::AIP_LVL_MID;
    case (cmp)
      2'h0:    lvl = aip_pkg::AIP_LVL_LOW;
      2'h1:    lvl = aip_pkg::AIP_LVL_MID;
      2'h3:    lvl = aip_pkg::AIP_LVL_HIGH;
      default: lvl = aip_pkg::AIP_LVL_MID; // impossible pair, treat as undriven
    endcase
    return lvl;
  endfunction : aip_decode_level

  // absence indication gated by the two-bit watch mode
  function automatic logic aip_absence(input logic [1:0] mode,
                                       input logic       normal,
                                       input logic       slow);
    logic res;
    res = 1'b0;
    case (mode)
      `AIP_WATCH_SLOW:   res = slow;
      `AIP_WATCH_NORMAL: res = normal;
      default:           res = 1'b0; // off and the reserved code watch nothing
    endcase
    return res;
  endfunction : aip_absence

  // pin level from a condition and its sense bit; sense 1 drives active high
  function automatic logic aip_sensed(input logic cond,
                                      input logic sense);
    return cond ~^ sense;
  endfunction : aip_sensed

  // address match shared by the four write decodes
  function automatic logic aip_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return addr == ofs;
  endfunction : aip_hit

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [1:0] absent_normal_s;
  logic [1:0] absent_slow_s;
  logic [1:0] deviation_s;
  logic [1:0] rate_low_s;
  logic [1:0] rate_high_s;

  // detector flags and pin comparators come from outside this clock
  // two edges of latency; a detector pulse shorter than one cycle can be missed
  aip_sync #(
    .W (10)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({refrate_sel_high_cmp, refrate_sel_low_cmp, freq_deviation,
                signal_absent_slow, signal_absent_normal}),
    .sync_out ({rate_high_s, rate_low_s, deviation_s, absent_slow_s, absent_normal_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] ctrl_q;
  logic [7:0] watch_q;
  logic [3:0] mask_q;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic       wr_ctrl;
  logic       wr_watch;
  logic       wr_status;
  logic       wr_mask;

  // live and rate are read only; writes there are dropped
  assign wr_ctrl   = reg_wr && aip_hit(reg_addr, `AIP_OFS_CTRL);
  assign wr_watch  = reg_wr && aip_hit(reg_addr, `AIP_OFS_WATCH);
  assign wr_status = reg_wr && aip_hit(reg_addr, `AIP_OFS_STATUS);
  assign wr_mask   = reg_wr && aip_hit(reg_addr, `AIP_OFS_MASK);

  // control: pin selects, level senses, deviation watch enables
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= `AIP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {1'b0, reg_wdata[6:0]}; // bit 7 unused, reads zero
    end
  end

  // absence watch modes for both inputs
  // the upper nibble is not stored and reads zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      watch_q <= `AIP_WATCH_RST;
    end else if (wr_watch) begin
      watch_q <= {4'h0, reg_wdata[3:0]};
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_q <= `AIP_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-input alarm conditions

  logic [1:0] absent_live;
  logic [1:0] dev_live;
  logic [1:0] alarm_live;
  logic [1:0] dev_watch;

  assign dev_watch = {ctrl_q[`AIP_CTRL_DEV_B], ctrl_q[`AIP_CTRL_DEV_A]};

  // one loop body for both inputs, so a and b decode alike
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_input
      // absence through the selected detector
      assign absent_live[gi] = aip_absence(watch_q[2*gi +: 2], absent_normal_s[gi],
                                           absent_slow_s[gi]);
      // deviation counts only while its watch bit is one
      assign dev_live[gi]    = dev_watch[gi] & deviation_s[gi];
      // 0 while the clock is good, 1 on absence or deviation
      assign alarm_live[gi]  = absent_live[gi] | dev_live[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sticky status and interrupt

  logic [3:0] live_flags;
  logic [3:0] clr_bits;

  assign live_flags = {dev_live, absent_live};
  assign clr_bits   = wr_status ? reg_wdata[3:0] : 4'h0;

  // a condition present in the clearing cycle keeps its bit set
  // clearing needs the condition gone, else the bit sets straight back
  always_comb begin
    status_d = (status_q & ~clr_bits) | live_flags;
  end

  // sticky flags
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_q <= `AIP_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  logic irq_any;

  // one reduction feeds the interrupt output and the combined pin alike
  assign irq_any = |(status_d & mask_q);

  // level interrupt from unmasked flags; built from the next status, so it
  // moves on the same edge as the status register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // combined pin function

  aip_pkg::aip_pin_mode_t pin_mode_q;
  aip_pkg::aip_pin_mode_t pin_mode_d;

  // the mode register costs one edge but keeps the select decode off the pin path
  // the interrupt select outranks the alarm select
  always_comb begin
    if (ctrl_q[`AIP_CTRL_IRQ_SEL]) begin
      pin_mode_d = aip_pkg::AIP_PIN_IRQ;
    end else if (ctrl_q[`AIP_CTRL_REF1_SEL]) begin
      pin_mode_d = aip_pkg::AIP_PIN_ALARM;
    end else begin
      pin_mode_d = aip_pkg::AIP_PIN_OFF;
    end
  end

  // mode register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_mode_q <= aip_pkg::AIP_PIN_OFF;
    end else begin
      pin_mode_q <= pin_mode_d;
    end
  end

  // drive the combined pin; sense bit 1 means active high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_or_ref1_alarm_pin_o  <= 1'b0;
      irq_or_ref1_alarm_pin_oe <= 1'b0;
    end else begin
      case (pin_mode_q)
        aip_pkg::AIP_PIN_IRQ: begin
          irq_or_ref1_alarm_pin_o  <= aip_sensed(irq_any,
                                                 ctrl_q[`AIP_CTRL_IRQ_SENSE]);
          irq_or_ref1_alarm_pin_oe <= 1'b1;
        end
        aip_pkg::AIP_PIN_ALARM: begin
          irq_or_ref1_alarm_pin_o  <= aip_sensed(alarm_live[0],
                                                 ctrl_q[`AIP_CTRL_ALM_SENSE]);
          irq_or_ref1_alarm_pin_oe <= 1'b1;
        end
        aip_pkg::AIP_PIN_OFF: begin
          irq_or_ref1_alarm_pin_o  <= 1'b0;
          irq_or_ref1_alarm_pin_oe <= 1'b0;
        end
        default: begin
          irq_or_ref1_alarm_pin_o  <= 1'b0;
          irq_or_ref1_alarm_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second status pin

  // the shared alarm sense covers both alarm pins
  // no mode register here, so this pin answers a select write one edge before the combined pin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref2_alarm_pin_o  <= 1'b0;
      ref2_alarm_pin_oe <= 1'b0;
    end else if (ctrl_q[`AIP_CTRL_REF2_SEL]) begin
      ref2_alarm_pin_o  <= aip_sensed(alarm_live[1], ctrl_q[`AIP_CTRL_ALM_SENSE]);
      ref2_alarm_pin_oe <= 1'b1;
    end else begin
      ref2_alarm_pin_o  <= 1'b0;
      ref2_alarm_pin_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference rate selection

  aip_pkg::aip_level_t rate_low_lvl;
  aip_pkg::aip_level_t rate_high_lvl;

  assign rate_low_lvl  = aip_decode_level(rate_low_s);
  assign rate_high_lvl = aip_decode_level(rate_high_s);

  logic [1:0] rate_prime_q;

  // the rate synchronisers restart at zero, which would read as a low pin;
  // hold the code at mid until both stages carry real pin samples
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rate_prime_q <= 2'h0;
    end else begin
      rate_prime_q <= {rate_prime_q[0], 1'b1};
    end
  end

  // one-hot level pair; the analog side maps it to reference type and rate
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      refrate_code <= {aip_pkg::AIP_LVL_MID, aip_pkg::AIP_LVL_MID};
    end else if (!rate_prime_q[1]) begin
      refrate_code <= {aip_pkg::AIP_LVL_MID, aip_pkg::AIP_LVL_MID};
    end else begin
      refrate_code <= {rate_high_lvl, rate_low_lvl};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  // data one cycle after the strobe; unmapped and idle reads return zero
  // live flags read raw, so software can tell a gone condition from a sticky bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AIP_OFS_CTRL:   reg_rdata <= ctrl_q;
        `AIP_OFS_WATCH:  reg_rdata <= watch_q;
        `AIP_OFS_STATUS: reg_rdata <= {4'h0, status_q};
        `AIP_OFS_MASK:   reg_rdata <= {4'h0, mask_q};
        `AIP_OFS_LIVE:   reg_rdata <= {2'h0, alarm_live, live_flags};
        `AIP_OFS_RATE:   reg_rdata <= {2'h0, refrate_code};
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : aip_top

`default_nettype wire

// ### test/aip_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side: resolves the two status pins as the board sees them
module aip_host_model (
  input  wire logic mclk,
  input  wire logic pin1_o,
  input  wire logic pin1_oe,
  input  wire logic pin2_o,
  input  wire logic pin2_oe,
  output logic      lvl1,
  output logic      lvl2
);
  logic last1_q;
  logic last2_q;

  // floating pins show the inverse of the last driven level, so a stale
  // value can never pass for a driven one
  always_ff @(posedge mclk) begin
    if (pin1_oe) last1_q <= pin1_o;
    if (pin2_oe) last2_q <= pin2_o;
  end

  assign lvl1 = pin1_oe ? pin1_o : ~last1_q;
  assign lvl2 = pin2_oe ? pin2_o : ~last2_q;
endmodule : aip_host_model

`default_nettype wire

// ### test/aip_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module aip_top_bench;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] ab_n = 2'h0;
  logic [1:0] ab_s = 2'h0;
  logic [1:0] dev = 2'h0;
  logic [1:0] lo_cmp = 2'h1;
  logic [1:0] hi_cmp = 2'h1;
  logic [7:0] rdata;
  logic [5:0] rcode;
  logic       p1_o, p1_oe, p2_o, p2_oe, irq, l1, l2, e;
  logic [1:0] cmp [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [2:0] hot [4] = '{3'h1, 3'h2, 3'h4, 3'h2};
  int         n_fail = 0;
  int         checks = 0;
  int         cyc = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  aip_top u_aip_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .signal_absent_normal(ab_n),
    .signal_absent_slow(ab_s), .freq_deviation(dev), .refrate_sel_low_cmp(lo_cmp),
    .refrate_sel_high_cmp(hi_cmp), .irq_or_ref1_alarm_pin_o(p1_o),
    .irq_or_ref1_alarm_pin_oe(p1_oe), .ref2_alarm_pin_o(p2_o), .ref2_alarm_pin_oe(p2_oe),
    .irq_o(irq), .refrate_code(rcode));
  aip_host_model u_aip_host_model (.mclk(mclk), .pin1_o(p1_o), .pin1_oe(p1_oe),
    .pin2_o(p2_o), .pin2_oe(p2_oe), .lvl1(l1), .lvl2(l2));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wreg

  // data is looked at in the one cycle it stands
  task automatic rreg(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 chk(rdata, x);
  endtask : rreg

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_n

  // each pin as {driven, level}; level ignored while floating
  task automatic pins(input logic [1:0] x1, input logic [1:0] x2);
    chk({4'h0, p1_oe, p1_oe & l1, p2_oe, p2_oe & l2}, {4'h0, x1, x2});
  endtask : pins

  // hang guard, well above the expected run of under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(8'h00, 8'h00);
    rreg(8'h04, 8'h00);
    rreg(8'h0c, 8'h00);
    rreg(8'h14, 8'h12);
    rreg(8'h40, 8'h00);
    pins(2'h0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      lo_cmp <= cmp[i];
      hi_cmp <= cmp[3-i];
      wait_n(4);
      rreg(8'h14, {2'h0, hot[3-i], hot[i]});
    end
    // every watch code against both detectors on both inputs, alarms active low
    wreg(8'h00, 8'h06);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 2; s++) begin
        wreg(8'h04, 8'(c * 5));
        @(posedge mclk);
        ab_n <= {2{s == 0}};
        ab_s <= {2{s == 1}};
        wait_n(5);
        e = (c == 3 && s == 0) || (c == 2 && s == 1);
        rreg(8'h10, {2'h0, e, e, 2'h0, e, e});
        pins({1'b1, ~e}, {1'b1, ~e});
        @(posedge mclk);
        ab_n <= 2'h0;
        ab_s <= 2'h0;
      end
    end
    wreg(8'h04, 8'h0f);
    wreg(8'h00, 8'h16);
    @(posedge mclk);
    ab_n <= 2'h2;
    wait_n(5);
    pins(2'h2, 2'h3);
    @(posedge mclk);
    ab_n <= 2'h0;
    dev  <= 2'h3;
    wait_n(5);
    pins(2'h2, 2'h2);
    wreg(8'h00, 8'h76);
    wait_n(3);
    pins(2'h3, 2'h3);
    @(posedge mclk);
    dev <= 2'h0;
    // interrupt use: raise, invert, mask, clear
    wreg(8'h00, 8'h01);
    rreg(8'h08, 8'h0f);
    wreg(8'h08, 8'h0f);
    wreg(8'h0c, 8'h01);
    wait_n(3);
    pins(2'h3, 2'h0);
    @(posedge mclk);
    ab_n <= 2'h1;
    wait_n(5);
    chk({7'h0, irq}, 8'h01);
    pins(2'h2, 2'h0);
    wreg(8'h00, 8'h09);
    wait_n(3);
    pins(2'h3, 2'h0);
    @(posedge mclk);
    ab_n <= 2'h0;
    wait_n(5);
    chk({7'h0, irq}, 8'h01);
    rreg(8'h08, 8'h01);
    wreg(8'h0c, 8'h00);
    wait_n(3);
    chk({7'h0, irq}, 8'h00);
    wreg(8'h0c, 8'h01);
    wait_n(3);
    chk({7'h0, irq}, 8'h01);
    wreg(8'h08, 8'h01);
    wait_n(3);
    chk({7'h0, irq}, 8'h00);
    rreg(8'h08, 8'h00);
    wreg(8'h00, 8'h00);
    wait_n(3);
    pins(2'h0, 2'h0);
    // reset in mid-run with both pins driven; rate code must sit at mid first
    wreg(8'h00, 8'h16);
    wait_n(3);
    pins(2'h2, 2'h2);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(8'h14, 8'h12);
    rreg(8'h00, 8'h00);
    wait_n(1);
    pins(2'h0, 2'h0);
    chk({7'h0, irq}, 8'h00);
    rreg(8'h14, 8'h0a);
    results();
  end
endmodule : aip_top_bench

bind aip_top aip_top_checker u_aip_top_checker (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .refrate_sel_low_cmp(refrate_sel_low_cmp),
  .refrate_sel_high_cmp(refrate_sel_high_cmp), .refrate_code(refrate_code), .irq_o(irq_o),
  .irq_or_ref1_alarm_pin_oe(irq_or_ref1_alarm_pin_oe), .ref2_alarm_pin_oe(ref2_alarm_pin_oe));

`default_nettype wire

// ### test/aip_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

// port-level checks of the alarm pin block
module aip_top_checker (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic [1:0] refrate_sel_low_cmp,
  input  wire logic [1:0] refrate_sel_high_cmp,
  input  wire logic [5:0] refrate_code,
  input  wire logic       irq_o,
  input  wire logic       irq_or_ref1_alarm_pin_oe,
  input  wire logic       ref2_alarm_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // read data only stands in the cycle after a read
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  // rate pins decode to one level each; [*5] covers sync plus register
  property p_low_hot;
    $onehot(refrate_code[2:0]);
  endproperty
  a_low_hot: assert property (p_low_hot) else $error("low rate code not one-hot");
  property p_high_hot;
    $onehot(refrate_code[5:3]);
  endproperty
  a_high_hot: assert property (p_high_hot) else $error("high rate code not one-hot");
  property p_low_l;
    (refrate_sel_low_cmp == 2'h0) [*5] |-> refrate_code[2:0] == 3'h1;
  endproperty
  a_low_l: assert property (p_low_l) else $error("low rate pin not low");
  property p_high_h;
    (refrate_sel_high_cmp == 2'h3) [*5] |-> refrate_code[5:3] == 3'h4;
  endproperty
  a_high_h: assert property (p_high_h) else $error("high rate pin not high");

  ////////////////////////////////////////////////////////////////////////////
  // pin drive only changes after a control write; the combined pin goes
  // through the mode register, so its drive follows the write strobe by three
  property p_oe1_cause;
    $changed(irq_or_ref1_alarm_pin_oe) |-> $past(reg_wr, 3);
  endproperty
  a_oe1_cause: assert property (p_oe1_cause) else $error("pin one drive changed alone");
  property p_oe2_cause;
    $changed(ref2_alarm_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_oe2_cause: assert property (p_oe2_cause) else $error("pin two drive changed alone");
  // sticky flags keep the interrupt up until software clears or masks
  property p_irq_fall;
    $fell(irq_o) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
endmodule : aip_top_checker

`default_nettype wire
